// file: tb_top.sv
// Purpose: self-checking bench of the wake and overcurrent supervisor
// Assumes: US_DIV of 1, so one tick is one clock
// Notes:   the retry interval alone takes about 50000 clocks
`timescale 1ns/1ps
module tb_top
   import wao_pkg::*;
;
   logic        clk = 1'b0, rstn = 1'b0, spi = 1'b0, len = 1'b0, tx = 1'b0;
   logic        aen = 1'b0, aoc = 1'b0, dis = 1'b0, clr = 1'b0, go = 1'b0, hold = 1'b0;
   logic [7:0]  glen = 8'h00;
   wao_strap_e  lstrap = WAO_STRAP_RES, astrap = WAO_STRAP_RES;
   wao_limreg_s lreg = 8'h00, areg = 8'h00;
   logic        rx, moc, woe, flag, reqh, f1, f2, lf, af, lal, aal, lm, am, wn, f1n, f2n;
   logic [2:0]  lc, ac;
   int          failures = 0, checked = 0, cycles = 0, n;

   always #20 clk = ~clk;

   wao_supervisor #(.US_DIV(8'h01)) wao_supervisor_inst (
      .sys_clk_in(clk), .resetn_in(rstn), .mode_spi_in(spi),
      .line_driver_enable_in(len), .line_transmit_input_in(tx),
      .line_receiver_output_in(rx), .line_overcurrent_in(moc | hold),
      .aux_driver_enable_in(aen), .aux_overcurrent_in(aoc),
      .line_limit_strap_in(lstrap), .aux_limit_strap_in(astrap),
      .line_limit_register_in(lreg), .aux_limit_register_in(areg),
      .wake_signal_disable_in(dis), .wake_flag_clear_in(clr),
      .wake_output_n_out(wn), .wake_oe_out(woe), .wake_interrupt_flag_out(flag),
      .wake_request_high_out(reqh), .first_fault_output_n_out(f1n),
      .first_fault_oe_out(f1), .second_fault_output_n_out(f2n), .second_fault_oe_out(f2),
      .line_fault_out(lf), .aux_fault_out(af), .line_drive_allow_out(lal),
      .aux_drive_allow_out(aal), .line_master_mode_out(lm), .aux_master_mode_out(am),
      .line_limit_code_out(lc), .aux_limit_code_out(ac));

   wao_line_master wao_line_master_inst (.sys_clk_in(clk), .go_in(go), .len_in(glen),
      .drv_on_in(len), .rx_out(rx), .oc_out(moc));

   task automatic conclude();
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string what, input logic exp, input logic got);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   function automatic logic pick(input int sel);
      case (sel)
         0: return woe;
         1: return lf;
         2: return af;
         default: return lal;
      endcase
   endfunction

   // bounded wait, n keeps the clocks spent
   task automatic wait_for(input int sel, input logic val, input int lim);
      n = 0;
      while (n < lim && pick(sel) !== val)
      begin
         tick(1);
         n++;
      end
   endtask

   task automatic pulse(input logic [7:0] k);
      @(posedge clk);
      go <= 1'b1;
      glen <= k;
      @(posedge clk);
      go <= 1'b0;
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 80000)
      begin
         failures++;
         conclude();
      end
   end

   initial
   begin
      tick(20);
      rstn <= 1'b1;
      tick(3);
      chk("wake idle", 1'b0, woe);
      chk("allow idle", 1'b1, lal);
      pulse(8'h50);
      wait_for(0, 1'b1, 120);
      chk("rx wake", 1'b1, woe);
      chk("wake pin level", 1'b0, wn);
      chk("pin flag", 1'b0, flag);
      wait_for(0, 1'b0, 300);
      chk("wake width", 1'b1, n inside {[175:285]});
      pulse(8'h1e);
      tick(150);
      chk("short wake", 1'b0, woe);
      pulse(8'h96);
      tick(300);
      chk("long wake", 1'b0, woe);
      spi <= 1'b1;
      len <= 1'b1;
      tick(5);
      pulse(8'h50);
      wait_for(0, 1'b1, 120);
      chk("oc wake", 1'b1, woe);
      chk("spi flag", 1'b1, flag);
      chk("low req", 1'b0, reqh);
      wait_for(0, 1'b0, 300);
      tx <= 1'b1;
      tick(5);
      pulse(8'h50);
      wait_for(0, 1'b1, 120);
      chk("high req", 1'b1, reqh);
      len <= 1'b0;
      wait_for(0, 1'b0, 300);
      clr <= 1'b1;
      tick(1);
      clr <= 1'b0;
      tick(2);
      chk("flag clear", 1'b0, flag);
      dis <= 1'b1;
      pulse(8'h50);
      tick(150);
      chk("dis wake", 1'b0, woe);
      chk("dis flag", 1'b0, flag);
      spi <= 1'b0;
      pulse(8'h50);
      wait_for(0, 1'b1, 120);
      chk("pin dis wake", 1'b1, woe);
      wait_for(0, 1'b0, 300);
      aen <= 1'b1;
      aoc <= 1'b1;
      tick(80);
      aoc <= 1'b0;
      tick(150);
      chk("aux wake", 1'b0, woe);
      spi <= 1'b1;
      lreg <= 8'ha0;
      areg <= 8'h40;
      tick(3);
      chk("line code", 1'b1, lc === 3'h5);
      chk("aux code", 1'b1, ac === 3'h2);
      spi <= 1'b0;
      lstrap <= WAO_STRAP_GND;
      tick(3);
      chk("pin code", 1'b1, lc === 3'h0);
      chk("line master", 1'b1, lm);
      chk("aux master", 1'b0, am);
      len <= 1'b1;
      hold <= 1'b1;
      tick(300);
      chk("gnd fault pin", 1'b0, f1);
      chk("gnd allow", 1'b1, lal);
      hold <= 1'b0;
      lstrap <= WAO_STRAP_RES;
      tick(5);
      hold <= 1'b1;
      wait_for(1, 1'b1, 400);
      chk("blank time", 1'b1, n inside {[195:210]});
      chk("fault pin one", 1'b1, f1);
      chk("fault pin one level", 1'b0, f1n);
      chk("retry off", 1'b0, lal);
      wait_for(3, 1'b1, 51000);
      chk("retry time", 1'b1, n inside {[49900:50100]});
      wait_for(3, 1'b0, 400);
      chk("probe time", 1'b1, n inside {[190:210]});
      len <= 1'b0;
      tick(2);
      chk("disabled fault", 1'b0, lf);
      lstrap <= WAO_STRAP_OPEN;
      len <= 1'b1;
      astrap <= WAO_STRAP_OPEN;
      aoc <= 1'b1;
      wait_for(2, 1'b1, 10);
      chk("open blank", 1'b1, n <= 4);
      chk("fault pin two", 1'b1, f2);
      chk("fault pin two level", 1'b0, f2n);
      tick(300);
      chk("open allow", 1'b1, aal);
      chk("open line fault", 1'b1, lf);
      chk("open line allow", 1'b1, lal);
      chk("held fault", 1'b1, af);
      aoc <= 1'b0;
      tick(3);
      conclude();
   end
endmodule

// file: wao_consts.svh
// Purpose: constants of the wake and overcurrent supervisor
// Assumes: 25 MHz system clock, timers counted in 1 us ticks
// Notes:   times are kept in their own unit, cycle counts derive from them
//
// Behaviour
// [R1] pin mode takes straps, spi mode takes programmed fields
// [R2] master wakes a device by inverting the line for about 80 us
// [R3] a valid wake drives the active-low wake pin for the wake pulse time
// [R4] local controller enters receive mode within 500 us of the wake
// [R5] driver off: receiver level change held within the window is a wake
// [R6] driver on: current at limit within the window is a wake, tx gives level
// [R7] overcurrent shorter or longer than the window never wakes
// [R8] spi mode also sets the sticky wake interrupt flag
// [R9] spi mode wake disable suppresses wake signalling; pin mode never
// [R10] aux channel never wakes but keeps overcurrent limiting and detection
// [R11] resistor strap: variable limit, 200 us blanking, auto-recovery
// [R12] grounded strap: master mode, no fault report, disable or recovery
// [R13] open strap: immediate fault report, no disable, no recovery
// [R14] spi mode limit per driver from bits 7:5 of its own register
// [R15] fault only after overcurrent lasts past the blanking time
// [R16] pin mode line fault pulls first fault pin, aux fault the second
// [R17] auto-recovery: off, then on for one blanking time every retry time
// [R18] without auto-recovery the driver keeps sourcing during a fault
// [R19] register holds limit, blanking, retry and auto-retry enable
// [R20] a disabled driver shows no overcurrent indication
// [R21] wake window 45..75 us to 85..145 us, wake pulse 175..285 us
// [R22] retry codes 0..3 give 50, 100, 200, 500 ms
// [R23] all intervals counted on one time base, restarting on loss
`ifndef WAO_CONSTS_SVH
`define WAO_CONSTS_SVH
`define WAO_CLK_MHZ       25
`define WAO_US_CYCLES     (1 * `WAO_CLK_MHZ)
`define WAO_WU_BEGIN_US   60
`define WAO_WU_END_US     100
`define WAO_WUL_US        225
`define WAO_BLANK0_US     200
`define WAO_BLANK1_US     500
`define WAO_BLANK2_US     5000
`define WAO_BLANK3_US     2
`define WAO_BLANK_PIN_US  200
`define WAO_RETRY0_US     (50 * 1000)
`define WAO_RETRY1_US     (100 * 1000)
`define WAO_RETRY2_US     (200 * 1000)
`define WAO_RETRY3_US     (500 * 1000)
`define WAO_PIN_LIMIT     3'h0
`define WAO_LIM_MSB       7
`define WAO_LIM_LSB       5
`endif

// file: wao_line_master.sv
// Purpose: line master that wakes the device by inverting the line
// Assumes: go_in is high for one clock, len_in counts clocks
// Notes:   a released line falls back to its idle level at once
`timescale 1ns/1ps
module wao_line_master
(
   input  wire logic       sys_clk_in, // clock
   input  wire logic       go_in,      // start a wake request
   input  wire logic [7:0] len_in,     // request length
   input  wire logic       drv_on_in,  // device driver enabled
   output logic            rx_out,     // receiver level seen
   output logic            oc_out      // device current at limit
);
   logic [7:0] left = 8'h00;
   always_ff @(posedge sys_clk_in)
   begin
      if (go_in)
         left <= len_in;
      else if (left != 8'h00)
         left <= left - 8'h01;
   end
   // a driven line fights the master, so the wake shows up as current at limit
   assign rx_out = (left != 8'h00) && !drv_on_in;
   assign oc_out = (left != 8'h00) && drv_on_in;
endmodule

// file: wao_ocp_channel.sv
// Purpose: overcurrent blanking, fault flag and auto-retry of one driver
// Assumes: oc_in is high while the output current sits at its limit
// Notes:   the retry-off phase ignores oc_in since the driver is off then
`timescale 1ns/1ps
module wao_ocp_channel
   import wao_pkg::*;
(
   input  wire logic       sys_clk_in,     // system clock
   input  wire logic       resetn_in,      // async reset, active low
   input  wire logic       tick_in,        // 1 us tick
   input  wire logic       enable_in,      // driver enable
   input  wire logic       oc_in,          // current at limit
   input  wire wao_chcfg_s cfg_in,         // timing and mode
   output logic            fault_out,      // qualified overcurrent
   output logic            drive_allow_out // low while retry keeps driver off
);
   wao_oc_state_e state;
   wao_us_t       cnt;

   always_ff @(posedge sys_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         state <= WAO_OC_IDLE;
         cnt   <= '0;
      end
      else if (!enable_in)
      begin
         state <= WAO_OC_IDLE; // R20
         cnt   <= '0;
      end
      else
      begin
         cnt <= cnt + wao_us_t'(tick_in); // R23
         case (state)
            WAO_OC_IDLE:
            begin
               cnt <= '0;
               if (oc_in)
                  state <= WAO_OC_BLANK;
            end
            WAO_OC_BLANK, WAO_OC_PROBE:
            begin
               if (!oc_in)
                  state <= WAO_OC_IDLE; // R23
               else if (cnt >= cfg_in.blank_us)
               begin
                  state <= cfg_in.autoretry ? WAO_OC_OFF : WAO_OC_HOLD; // R15 R17 R18
                  cnt   <= '0;
               end
            end
            WAO_OC_HOLD:
               if (!oc_in)
                  state <= WAO_OC_IDLE;
            WAO_OC_OFF:
            begin
               if (!cfg_in.autoretry)
                  state <= WAO_OC_HOLD; // R18
               else if (cnt >= cfg_in.retry_us)
               begin
                  state <= WAO_OC_PROBE; // R17
                  cnt   <= '0;
               end
            end
            default:
               state <= WAO_OC_IDLE;
         endcase
      end
   end

   assign fault_out = enable_in && cfg_in.report && (state == WAO_OC_HOLD
                      || state == WAO_OC_OFF || state == WAO_OC_PROBE); // R20
   assign drive_allow_out = (state != WAO_OC_OFF);
endmodule

// file: wao_pkg.sv
// Purpose: types of the wake and overcurrent supervisor
// Assumes: register layout limit[7:5] blank[4:3] retry[2:1] autoretry[0]
// Notes:   timer values travel in 1 us ticks, 19 bits reach 500 ms
package wao_pkg;
   typedef logic [18:0] wao_us_t;
   typedef enum logic [1:0] {
      WAO_STRAP_RES  = 2'b00,
      WAO_STRAP_GND  = 2'b01,
      WAO_STRAP_OPEN = 2'b10
   } wao_strap_e;
   typedef struct packed {
      logic [2:0] limit;
      logic [1:0] blank;
      logic [1:0] retry;
      logic       autoretry;
   } wao_limreg_s;
   typedef struct packed {
      wao_us_t blank_us;
      wao_us_t retry_us;
      logic    report;
      logic    autoretry;
   } wao_chcfg_s;
   typedef enum logic [2:0] {
      WAO_OC_IDLE  = 3'b000,
      WAO_OC_BLANK = 3'b001,
      WAO_OC_HOLD  = 3'b010,
      WAO_OC_OFF   = 3'b011,
      WAO_OC_PROBE = 3'b100
   } wao_oc_state_e;
endpackage

// file: wao_supervisor.sv
// Purpose: wake detection and overcurrent supervision of the line and aux drivers
// Assumes: all inputs synchronous to sys_clk_in; analog limit set elsewhere
// Notes:   open-drain pins come out as value plus enable, value always low
`include "wao_consts.svh"
`timescale 1ns/1ps
module wao_supervisor
   import wao_pkg::*;
#(
   parameter logic [7:0] US_DIV = 8'(`WAO_US_CYCLES)
)
(
   input  wire logic        sys_clk_in,                // system clock, 25 MHz
   input  wire logic        resetn_in,                 // async reset, active low
   input  wire logic        mode_spi_in,               // 0 straps, 1 programmed
   input  wire logic        line_driver_enable_in,     // line driver enable
   input  wire logic        line_transmit_input_in,    // line transmit level
   input  wire logic        line_receiver_output_in,   // line receiver level
   input  wire logic        line_overcurrent_in,       // line current at limit
   input  wire logic        aux_driver_enable_in,      // aux driver enable
   input  wire logic        aux_overcurrent_in,        // aux current at limit
   input  wire wao_strap_e  line_limit_strap_in,       // line strap state
   input  wire wao_strap_e  aux_limit_strap_in,        // aux strap state
   input  wire wao_limreg_s line_limit_register_in,    // line limit register
   input  wire wao_limreg_s aux_limit_register_in,     // aux limit register
   input  wire logic        wake_signal_disable_in,    // spi wake disable
   input  wire logic        wake_flag_clear_in,        // clears the wake flag
   output logic             wake_output_n_out,         // wake pin value
   output logic             wake_oe_out,               // wake pin drive
   output logic             wake_interrupt_flag_out,   // sticky wake status
   output logic             wake_request_high_out,     // level of last wake
   output logic             first_fault_output_n_out,  // line fault pin value
   output logic             first_fault_oe_out,        // line fault pin drive
   output logic             second_fault_output_n_out, // aux fault pin value
   output logic             second_fault_oe_out,       // aux fault pin drive
   output logic             line_fault_out,            // line fault status
   output logic             aux_fault_out,             // aux fault status
   output logic             line_drive_allow_out,      // line driver gate
   output logic             aux_drive_allow_out,       // aux driver gate
   output logic             line_master_mode_out,      // line master mode
   output logic             aux_master_mode_out,       // aux master mode
   output logic [2:0]       line_limit_code_out,       // line limit select
   output logic [2:0]       aux_limit_code_out         // aux limit select
);
   ////////////////////////////////////////////////////////////////////////////
   localparam logic [7:0] WU_BEGIN = 8'(`WAO_WU_BEGIN_US);
   localparam logic [7:0] WU_END   = 8'(`WAO_WU_END_US);
   localparam logic [8:0] WUL      = 9'(`WAO_WUL_US);
   localparam logic [7:0] DEV_MAX  = 8'hFF;

   logic       tick;
   logic       line_fault;
   logic       aux_fault;
   logic       line_allow;
   logic       aux_allow;
   logic       ref_level;
   logic       en_q;
   logic       dev;
   logic       wake_hit;
   logic       wake_allowed;
   logic       wake_start;
   logic       wake_active;
   logic [7:0] dev_cnt;
   logic [8:0] pulse_cnt;
   wao_chcfg_s line_cfg;
   wao_chcfg_s aux_cfg;

   function automatic wao_chcfg_s cfg_of(input logic spi, input wao_strap_e strap,
                                         input wao_limreg_s r);
      wao_chcfg_s c;
      c.report    = 1'b1;
      c.autoretry = 1'b0;
      c.retry_us  = wao_us_t'(`WAO_RETRY0_US);
      c.blank_us  = wao_us_t'(`WAO_BLANK_PIN_US);
      if (spi)
      begin
         c.autoretry = r.autoretry; // R19
         case (r.blank)
            2'b00:   c.blank_us = wao_us_t'(`WAO_BLANK0_US);
            2'b01:   c.blank_us = wao_us_t'(`WAO_BLANK1_US);
            2'b10:   c.blank_us = wao_us_t'(`WAO_BLANK2_US);
            default: c.blank_us = wao_us_t'(`WAO_BLANK3_US);
         endcase
         case (r.retry)
            2'b00:   c.retry_us = wao_us_t'(`WAO_RETRY0_US); // R22
            2'b01:   c.retry_us = wao_us_t'(`WAO_RETRY1_US);
            2'b10:   c.retry_us = wao_us_t'(`WAO_RETRY2_US);
            default: c.retry_us = wao_us_t'(`WAO_RETRY3_US);
         endcase
      end
      else
      begin
         case (strap) // R1
            WAO_STRAP_RES:
               c.autoretry = 1'b1; // R11
            WAO_STRAP_GND:
               c.report = 1'b0; // R12
            WAO_STRAP_OPEN:
               c.blank_us = '0; // R13
            default:
               c.report = 1'b1;
         endcase
      end
      return c;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // configuration and submodules

   assign line_cfg = cfg_of(mode_spi_in, line_limit_strap_in, line_limit_register_in);
   assign aux_cfg  = cfg_of(mode_spi_in, aux_limit_strap_in, aux_limit_register_in);

   wao_timebase #(
      .DIV        (US_DIV)
   ) u_timebase (
      .sys_clk_in (sys_clk_in),
      .resetn_in  (resetn_in),
      .tick_out   (tick)
   );

   wao_ocp_channel u_line_ocp (
      .sys_clk_in      (sys_clk_in),
      .resetn_in       (resetn_in),
      .tick_in         (tick),
      .enable_in       (line_driver_enable_in),
      .oc_in           (line_overcurrent_in),
      .cfg_in          (line_cfg),
      .fault_out       (line_fault),
      .drive_allow_out (line_allow)
   );

   // the aux channel has no wake path at all
   wao_ocp_channel u_aux_ocp (
      .sys_clk_in      (sys_clk_in),
      .resetn_in       (resetn_in),
      .tick_in         (tick),
      .enable_in       (aux_driver_enable_in),
      .oc_in           (aux_overcurrent_in),
      .cfg_in          (aux_cfg),
      .fault_out       (aux_fault),
      .drive_allow_out (aux_allow)
   ); // R10

   ////////////////////////////////////////////////////////////////////////////
   // wake recognition: a deviation must end inside the window

   // receiver side counts a departure from the settled level
   assign dev = line_driver_enable_in ? line_overcurrent_in
                                      : (line_receiver_output_in != ref_level); // R5 R6
   assign wake_hit = !dev && (dev_cnt >= WU_BEGIN) && (dev_cnt < WU_END); // R7 R21
   assign wake_allowed = !(mode_spi_in && wake_signal_disable_in); // R9
   assign wake_active = (pulse_cnt != 9'h000);
   assign wake_start = wake_hit && wake_allowed && !wake_active;

   always_ff @(posedge sys_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         en_q <= 1'b0;
      else
         en_q <= line_driver_enable_in;
   end

   // a change that outlasts the window becomes the new settled level
   always_ff @(posedge sys_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         ref_level <= 1'b0;
      else if (line_driver_enable_in)
         ref_level <= line_receiver_output_in;
      else if (dev && dev_cnt >= WU_END)
         ref_level <= line_receiver_output_in;
   end

   // a change of driver mode restarts the measurement so no mixed pulse counts
   always_ff @(posedge sys_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         dev_cnt <= 8'h00;
      else if (!dev || en_q != line_driver_enable_in)
         dev_cnt <= 8'h00; // R23
      else if (tick && dev_cnt != DEV_MAX)
         dev_cnt <= dev_cnt + 8'h01;
   end

   ////////////////////////////////////////////////////////////////////////////
   // wake pulse and flag; a new wake during a pulse is absorbed by it

   always_ff @(posedge sys_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         pulse_cnt <= 9'h000;
      else if (wake_start)
         pulse_cnt <= WUL; // R3
      else if (tick && wake_active)
         pulse_cnt <= pulse_cnt - 9'h001;
   end

   always_ff @(posedge sys_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         wake_interrupt_flag_out <= 1'b0;
      else if (wake_start && mode_spi_in)
         wake_interrupt_flag_out <= 1'b1; // R8
      else if (wake_flag_clear_in)
         wake_interrupt_flag_out <= 1'b0;
   end

   always_ff @(posedge sys_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         wake_request_high_out <= 1'b0;
      else if (wake_start)
         wake_request_high_out <= line_transmit_input_in; // R6
   end

   assign wake_output_n_out = 1'b0;
   assign wake_oe_out = wake_active; // R3

   ////////////////////////////////////////////////////////////////////////////
   // fault pins and driver controls

   always_ff @(posedge sys_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         line_limit_code_out  <= 3'h0;
         aux_limit_code_out   <= 3'h0;
         line_master_mode_out <= 1'b0;
         aux_master_mode_out  <= 1'b0;
      end
      else
      begin
         line_limit_code_out  <= mode_spi_in ? line_limit_register_in.limit
                                             : `WAO_PIN_LIMIT; // R14
         aux_limit_code_out   <= mode_spi_in ? aux_limit_register_in.limit
                                             : `WAO_PIN_LIMIT;
         line_master_mode_out <= !mode_spi_in && line_limit_strap_in == WAO_STRAP_GND; // R12
         aux_master_mode_out  <= !mode_spi_in && aux_limit_strap_in == WAO_STRAP_GND;
      end
   end

   assign first_fault_output_n_out  = 1'b0;
   assign second_fault_output_n_out = 1'b0;
   assign first_fault_oe_out   = !mode_spi_in && line_fault; // R16
   assign second_fault_oe_out  = !mode_spi_in && aux_fault; // R16
   assign line_fault_out       = line_fault;
   assign aux_fault_out        = aux_fault;
   assign line_drive_allow_out = line_allow; // R17 R18
   assign aux_drive_allow_out  = aux_allow;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   logic [15:0] oe_len;
   int unsigned wul_lo;
   int unsigned wul_hi;

   assign wul_lo = (`WAO_WUL_US - 1) * int'(US_DIV) + 1;
   assign wul_hi = `WAO_WUL_US * int'(US_DIV);

   always_ff @(posedge sys_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         oe_len <= 16'h0000;
      else if (wake_oe_out)
         oe_len <= oe_len + 16'h0001;
      else
         oe_len <= 16'h0000;
   end

   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!resetn_in);

   property p_wake_len;
      $fell(wake_oe_out) |-> ($past(oe_len) + 1 >= wul_lo) && ($past(oe_len) + 1 <= wul_hi);
   endproperty
   a_wake_len: assert property (p_wake_len) else $error("wake pulse length off"); // R3

   property p_wake_start;
      wake_hit && wake_allowed && !wake_oe_out |=> wake_oe_out && !wake_output_n_out;
   endproperty
   a_wake_start: assert property (p_wake_start) else $error("valid wake not signalled"); // R5

   property p_wake_disable;
      $rose(wake_oe_out) |-> !$past(mode_spi_in && wake_signal_disable_in);
   endproperty
   a_wake_disable: assert property (p_wake_disable) else $error("wake while disabled"); // R9

   property p_flag_set;
      $rose(wake_oe_out) && $past(mode_spi_in) |-> wake_interrupt_flag_out;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("wake flag not set"); // R8

   property p_short_pulse;
      !dev && dev_cnt != 8'h00 && dev_cnt < WU_BEGIN && !wake_oe_out |=> !wake_oe_out;
   endproperty
   a_short_pulse: assert property (p_short_pulse) else $error("short pulse woke"); // R7

   property p_long_pulse;
      !dev && dev_cnt >= WU_END && !wake_oe_out |=> !wake_oe_out;
   endproperty
   a_long_pulse: assert property (p_long_pulse) else $error("long pulse woke"); // R7

   property p_disabled_quiet;
      !line_driver_enable_in || !aux_driver_enable_in |-> !(line_fault && !line_driver_enable_in)
                                                          && !(aux_fault && !aux_driver_enable_in);
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet) else $error("fault while disabled"); // R20

   property p_aux_pin;
      $rose(second_fault_oe_out) |-> !mode_spi_in && $past(aux_overcurrent_in);
   endproperty
   a_aux_pin: assert property (p_aux_pin) else $error("aux fault pin without cause"); // R16

   property p_open_immediate;
      !mode_spi_in && line_limit_strap_in == WAO_STRAP_OPEN
      && (line_driver_enable_in && line_overcurrent_in) [*3] |-> line_fault_out;
   endproperty
   a_open_immediate: assert property (p_open_immediate) else $error("open strap slow"); // R13

   property p_master_quiet;
      !mode_spi_in && line_limit_strap_in == WAO_STRAP_GND |-> !first_fault_oe_out;
   endproperty
   a_master_quiet: assert property (p_master_quiet) else $error("master mode fault"); // R12

   property p_retry_off;
      $fell(line_drive_allow_out) |-> (!line_drive_allow_out || !line_driver_enable_in) [*8];
   endproperty
   a_retry_off: assert property (p_retry_off) else $error("retry off too short"); // R17

   property p_no_retry_on;
      (!line_cfg.autoretry) [*2] |-> line_drive_allow_out;
   endproperty
   a_no_retry_on: assert property (p_no_retry_on) else $error("driver off w/o retry"); // R18

   property p_limit_code;
      mode_spi_in ##1 mode_spi_in |-> line_limit_code_out == $past(line_limit_register_in.limit);
   endproperty
   a_limit_code: assert property (p_limit_code) else $error("limit code mismatch"); // R14

   c_wake_rx: cover property (!line_driver_enable_in && $rose(wake_oe_out));
   c_wake_oc: cover property (line_driver_enable_in && $rose(wake_oe_out));
   c_line_fault: cover property ($rose(first_fault_oe_out));
   c_retry: cover property ($rose(line_drive_allow_out));
endmodule

// file: wao_timebase.sv
// Purpose: one-cycle tick every microsecond
// Assumes: DIV system clocks per microsecond
// Notes:   shared by every timer so all intervals use one base
`timescale 1ns/1ps
module wao_timebase
   import wao_pkg::*;
#(
   parameter logic [7:0] DIV = 8'd25
)
(
   input  wire logic sys_clk_in,  // system clock
   input  wire logic resetn_in,   // async reset, active low
   output logic      tick_out     // 1 us enable pulse
);
   logic [7:0] div_cnt;

   always_ff @(posedge sys_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         div_cnt <= 8'h00;
      else if (div_cnt >= DIV - 8'd1)
         div_cnt <= 8'h00;
      else
         div_cnt <= div_cnt + 8'd1;
   end

   assign tick_out = (div_cnt == 8'h00);
endmodule
